// [design/wdt_filt.sv]
`timescale 1ns/1ps
module wdt_filt #(
  parameter int unsigned N   = 300,
  parameter logic        RST = 1'b0
) (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic TICK,
  input  wire logic IN,
  output logic      OUT
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        out_d;

  // A level must stay different across N tick pulses in a row before it is taken
  always_comb begin
    out_d = OUT;
    cnt_d = cnt_q;
    if (IN == OUT) begin
      cnt_d = 12'h000;
    end else if (TICK && cnt_q == 12'(N - 1)) begin
      out_d = IN;
      cnt_d = 12'h000;
    end else if (TICK) begin
      cnt_d = cnt_q + 12'h001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cnt_q <= 12'h000;
      OUT   <= RST;
    end else begin
      cnt_q <= cnt_d;
      OUT   <= out_d;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  filt_change_a: assert property ($changed(OUT) |-> $past(TICK) && $past(cnt_q) == 12'(N - 1)
                                  && $past(IN) != $past(OUT))
    else $error("filtered level changed before its hold time");
  filt_bound_a: assert property (cnt_q <= 12'(N - 1))
    else $error("filter counter ran past its limit");
endmodule

// [design/wdt_pkg.sv]
package wdt_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned NS_PER_US      = 1000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam int unsigned TRIG_SEL0_US    = 96000;
  localparam int unsigned TRIG_SEL1_US    = 48000;
  localparam int unsigned TRIG_SEL2_US    = 32000;
  localparam int unsigned TRIG_SEL3_US    = 16000;
  localparam int unsigned IGNORE_US       = 16000;
  localparam int unsigned FAULT_LOW_US    = 8000;
  localparam int unsigned STATE_FILTER_US = 300;
  localparam int unsigned STRAP_GUARD_US  = 160;

  localparam int unsigned TRIG_SEL0_TICKS    = TRIG_SEL0_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned TRIG_SEL1_TICKS    = TRIG_SEL1_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned TRIG_SEL2_TICKS    = TRIG_SEL2_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned TRIG_SEL3_TICKS    = TRIG_SEL3_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned IGNORE_TICKS       = IGNORE_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned FAULT_LOW_TICKS    = FAULT_LOW_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned STATE_FILTER_TICKS = STATE_FILTER_US * NS_PER_US / TICK_PERIOD_NS;
  localparam int unsigned STRAP_GUARD_TICKS  = STRAP_GUARD_US * NS_PER_US / TICK_PERIOD_NS;

  localparam int unsigned AXI_ADDR_W = 4;
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_CLEAR  = 4'h4;
  localparam logic [3:0]  REG_ENABLE = 4'h8;
  localparam logic [3:0]  REG_STATE  = 4'hc;

  localparam int unsigned EV_W       = 4;
  localparam int unsigned EV_MISS    = 0;
  localparam int unsigned EV_SERVICE = 1;
  localparam int unsigned EV_DEACT   = 2;
  localparam int unsigned EV_REACT   = 3;
  localparam logic [3:0]  STATUS_RST = 4'h0;
  localparam logic [3:0]  ENABLE_RST = 4'h0;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    WDT_ST_IGNORE  = 2'h0,
    WDT_ST_TRIGGER = 2'h1,
    WDT_ST_FAULT   = 2'h3,
    WDT_ST_OFF     = 2'h2
  } wdt_state_type;

endpackage

// [design/wdt_tick.sv]
`timescale 1ns/1ps
module wdt_tick #(
  parameter int unsigned DIV = 10
) (
  input  wire logic CLK,
  input  wire logic SRST,
  output logic      TICK
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_d;

  always_comb begin
    tick_d = (cnt_q == 8'(DIV - 1));
    cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cnt_q <= 8'h00;
      TICK  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      TICK  <= tick_d;
    end
  end
endmodule

// [design/wdt_top.sv]
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module wdt_top #(
  parameter int unsigned TRIG0_TICKS  = wdt_pkg::TRIG_SEL0_TICKS,
  parameter int unsigned TRIG1_TICKS  = wdt_pkg::TRIG_SEL1_TICKS,
  parameter int unsigned TRIG2_TICKS  = wdt_pkg::TRIG_SEL2_TICKS,
  parameter int unsigned TRIG3_TICKS  = wdt_pkg::TRIG_SEL3_TICKS,
  parameter int unsigned IGN_TICKS    = wdt_pkg::IGNORE_TICKS,
  parameter int unsigned FLOW_TICKS   = wdt_pkg::FAULT_LOW_TICKS,
  parameter int unsigned FILTER_TICKS = wdt_pkg::STATE_FILTER_TICKS,
  parameter int unsigned GUARD_TICKS  = wdt_pkg::STRAP_GUARD_TICKS
) (
  input  wire logic                             CLK,
  input  wire logic                             SRST,
  input  wire logic                             WINDOW_SELECT_A,
  input  wire logic                             WINDOW_SELECT_B,
  input  wire logic                             SERVICE_INPUT,
  input  wire logic                             LOW_CURRENT,
  input  wire logic                             DISABLE_LEVEL,
  output logic                                  FAULT_OUTPUT_N,
  output logic                                  IRQ,
  input  wire logic [wdt_pkg::AXI_ADDR_W-1:0]   AWADDR,
  input  wire logic                             AWVALID,
  output logic                                  AWREADY,
  input  wire logic [31:0]                      WDATA,
  input  wire logic [3:0]                       WSTRB,
  input  wire logic                             WVALID,
  output logic                                  WREADY,
  output logic [1:0]                            BRESP,
  output logic                                  BVALID,
  input  wire logic                             BREADY,
  input  wire logic [wdt_pkg::AXI_ADDR_W-1:0]   ARADDR,
  input  wire logic                             ARVALID,
  output logic                                  ARREADY,
  output logic [31:0]                           RDATA,
  output logic [1:0]                            RRESP,
  output logic                                  RVALID,
  input  wire logic                             RREADY
);
  import wdt_pkg::*;

  localparam int unsigned NSYNC = 5;
  localparam int unsigned CNT_W = 17;

  logic             tick;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic             svc_prev_q;
  logic             svc_fall;
  logic             lowc_f;
  logic             dis_f;
  logic             act_f;
  logic             act_prev_q;
  logic [1:0]       strap_f;

  wdt_tick #(.DIV(TICK_CYCLES)) u_tick (
    .CLK  (CLK),
    .SRST (SRST),
    .TICK (tick)
  );

  // Inputs are asynchronous pads in silicon, so each gets two stages
  assign pins = {DISABLE_LEVEL, LOW_CURRENT, SERVICE_INPUT, WINDOW_SELECT_B, WINDOW_SELECT_A};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge CLK) begin
      if (SRST) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  for (genvar j = 0; j < 2; j++) begin : g_strap
    wdt_filt #(.N(GUARD_TICKS), .RST(1'b0)) u_strap (
      .CLK  (CLK),
      .SRST (SRST),
      .TICK (tick),
      .IN   (s2_q[j]),
      .OUT  (strap_f[j])
    );
  end

  wdt_filt #(.N(FILTER_TICKS), .RST(1'b0)) u_lowc (
    .CLK  (CLK),
    .SRST (SRST),
    .TICK (tick),
    .IN   (s2_q[3]),
    .OUT  (lowc_f)
  );

  wdt_filt #(.N(FILTER_TICKS), .RST(1'b0)) u_dis (
    .CLK  (CLK),
    .SRST (SRST),
    .TICK (tick),
    .IN   (s2_q[4]),
    .OUT  (dis_f)
  );

  assign act_f = !lowc_f && !dis_f;
  // A disable level reads as neither high nor low, so no edge is trusted then
  assign svc_fall = svc_prev_q && !s2_q[2] && !s2_q[4];

  // Watchdog sequencer
  wdt_state_type    st_q;
  wdt_state_type    st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0]       sel_q;
  logic [1:0]       sel_d;
  logic             fault_n_d;
  logic [CNT_W-1:0] win_m1;
  logic             ev_miss;

  always_comb begin
    case (sel_q)
      2'h0:    win_m1 = CNT_W'(TRIG0_TICKS - 1);
      2'h1:    win_m1 = CNT_W'(TRIG1_TICKS - 1);
      2'h2:    win_m1 = CNT_W'(TRIG2_TICKS - 1);
      default: win_m1 = CNT_W'(TRIG3_TICKS - 1);
    endcase
  end

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    sel_d     = sel_q;
    fault_n_d = FAULT_OUTPUT_N;
    ev_miss   = 1'b0;
    case (st_q)
      WDT_ST_IGNORE: begin
        if (!act_f) begin
          st_d  = WDT_ST_OFF;
          cnt_d = '0;
        end else if (tick && cnt_q == CNT_W'(IGN_TICKS - 1)) begin
          st_d  = WDT_ST_TRIGGER;
          cnt_d = '0;
          sel_d = strap_f;
        end else if (tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      WDT_ST_TRIGGER: begin
        if (!act_f) begin
          st_d  = WDT_ST_OFF;
          cnt_d = '0;
        end else if (svc_fall) begin
          cnt_d = '0;
          sel_d = strap_f;
        end else if (tick && cnt_q == win_m1) begin
          st_d      = WDT_ST_FAULT;
          cnt_d     = '0;
          fault_n_d = 1'b0;
          ev_miss   = 1'b1;
        end else if (tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      WDT_ST_FAULT: begin
        // The low time runs to its end even if the watchdog is switched off
        if (tick && cnt_q == CNT_W'(FLOW_TICKS - 1)) begin
          fault_n_d = 1'b1;
          cnt_d     = '0;
          st_d      = act_f ? WDT_ST_IGNORE : WDT_ST_OFF;
        end else if (tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      WDT_ST_OFF: begin
        fault_n_d = 1'b1;
        cnt_d     = '0;
        if (act_f) begin
          st_d = WDT_ST_IGNORE;
        end
      end
      default: begin
        st_d      = WDT_ST_IGNORE;
        cnt_d     = '0;
        fault_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q           <= WDT_ST_IGNORE;
      cnt_q          <= '0;
      sel_q          <= 2'h0;
      FAULT_OUTPUT_N <= 1'b1;
      svc_prev_q     <= 1'b0;
      act_prev_q     <= 1'b1;
    end else begin
      st_q           <= st_d;
      cnt_q          <= cnt_d;
      sel_q          <= sel_d;
      FAULT_OUTPUT_N <= fault_n_d;
      svc_prev_q     <= s2_q[2];
      act_prev_q     <= act_f;
    end
  end

  // Register file and interrupt
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] status_d;
  logic [EV_W-1:0] en_q;
  logic [EV_W-1:0] en_d;
  logic [EV_W-1:0] clr;
  logic            irq_d;
  logic            aw_have_q;
  logic            aw_have_d;
  logic            w_have_q;
  logic            w_have_d;
  logic [3:0]      waddr_q;
  logic [3:0]      waddr_d;
  logic [31:0]     wdata_q;
  logic [31:0]     wdata_d;
  logic            wlane_q;
  logic            wlane_d;
  logic            bvalid_d;
  logic [1:0]      bresp_d;
  logic            rvalid_d;
  logic [31:0]     rdata_d;
  logic [1:0]      rresp_d;

  always_comb begin
    events             = '0;
    events[EV_MISS]    = ev_miss;
    events[EV_SERVICE] = svc_fall && st_q == WDT_ST_TRIGGER && act_f;
    events[EV_DEACT]   = act_prev_q && !act_f;
    events[EV_REACT]   = !act_prev_q && act_f;
  end

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    wlane_d   = wlane_q;
    bvalid_d  = BVALID;
    bresp_d   = BRESP;
    en_d      = en_q;
    clr       = '0;
    if (AWVALID && AWREADY) begin
      aw_have_d = 1'b1;
      waddr_d   = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_have_d = 1'b1;
      wdata_d  = WDATA;
      wlane_d  = WSTRB[0];
    end
    if (BVALID && BREADY) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !BVALID) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (waddr_q)
        REG_CLEAR:  clr = wlane_q ? wdata_q[EV_W-1:0] : '0;
        REG_ENABLE: en_d = wlane_q ? wdata_q[EV_W-1:0] : en_q;
        REG_STATUS: bresp_d = RESP_OKAY;
        REG_STATE:  bresp_d = RESP_OKAY;
        default:    bresp_d = RESP_DECERR;
      endcase
    end
    // Set wins over a clear landing in the same cycle
    status_d = (status_q & ~clr) | events;
    irq_d    = |(status_d & en_d);
  end

  always_comb begin
    rvalid_d = RVALID;
    rdata_d  = RDATA;
    rresp_d  = RRESP;
    if (RVALID && RREADY) begin
      rvalid_d = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (ARADDR)
        REG_STATUS: rdata_d = {28'h0000000, status_q};
        REG_ENABLE: rdata_d = {28'h0000000, en_q};
        REG_STATE:  rdata_d = {24'h000000, strap_f, sel_q, act_f, FAULT_OUTPUT_N, st_q};
        REG_CLEAR:  rdata_d = 32'h00000000;
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 4'h0;
      wdata_q   <= 32'h00000000;
      wlane_q   <= 1'b0;
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
      ARREADY   <= 1'b0;
      RVALID    <= 1'b0;
      RDATA     <= 32'h00000000;
      RRESP     <= RESP_OKAY;
      status_q  <= STATUS_RST;
      en_q      <= ENABLE_RST;
      IRQ       <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wlane_q   <= wlane_d;
      AWREADY   <= !aw_have_d && !bvalid_d;
      WREADY    <= !w_have_d && !bvalid_d;
      BVALID    <= bvalid_d;
      BRESP     <= bresp_d;
      ARREADY   <= !rvalid_d;
      RVALID    <= rvalid_d;
      RDATA     <= rdata_d;
      RRESP     <= rresp_d;
      status_q  <= status_d;
      en_q      <= en_d;
      IRQ       <= irq_d;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence miss_seq;
    st_q == WDT_ST_TRIGGER && act_f && !svc_fall && tick && cnt_q == win_m1;
  endsequence
  sequence low_done_seq;
    st_q == WDT_ST_FAULT && tick && cnt_q == CNT_W'(FLOW_TICKS - 1);
  endsequence

  miss_fault_a: assert property (miss_seq |=> !FAULT_OUTPUT_N && st_q == WDT_ST_FAULT)
    else $error("missed window did not pull the fault output low");
  fault_release_a: assert property ($rose(FAULT_OUTPUT_N) |-> $past(st_q) == WDT_ST_FAULT
                                    && $past(cnt_q) == CNT_W'(FLOW_TICKS - 1))
    else $error("fault output released at the wrong time");
  ignore_start_a: assert property (low_done_seq ##0 act_f |=> st_q == WDT_ST_IGNORE
                                   && cnt_q == '0 && FAULT_OUTPUT_N)
    else $error("ignore window did not follow the fault release");
  service_restart_a: assert property (st_q == WDT_ST_TRIGGER && act_f && svc_fall
                                      |=> st_q == WDT_ST_TRIGGER && cnt_q == '0)
    else $error("service event did not restart the window");
  window_len_a: assert property (st_q == WDT_ST_TRIGGER && st_d == WDT_ST_FAULT
                                 |-> cnt_q == (sel_q == 2'h0 ? CNT_W'(TRIG0_TICKS - 1) :
                                              sel_q == 2'h1 ? CNT_W'(TRIG1_TICKS - 1) :
                                              sel_q == 2'h2 ? CNT_W'(TRIG2_TICKS - 1) :
                                                              CNT_W'(TRIG3_TICKS - 1)))
    else $error("trigger window length does not match the straps");
  off_state_a: assert property (!act_f && st_q != WDT_ST_FAULT |=> st_q == WDT_ST_OFF
                                && FAULT_OUTPUT_N)
    else $error("watchdog not off while inactive");
  sync_path_a: assert property (svc_fall |-> $past(s2_q[2]) && !s2_q[2])
    else $error("service edge not taken from the second stage");
endmodule

// [tb/regulator_watchdog_timing_select_test.sv]
`timescale 1ns/1ps
module regulator_watchdog_timing_select_test;
  import wdt_pkg::*;
  localparam int TK   = 10;
  localparam int FLOW = 8;
  localparam int IGN  = 16;
  localparam int T0   = 40;
  localparam int T1   = 30;
  localparam int T2   = 20;
  localparam int T3   = 10;
  localparam int FILT = 5;
  localparam int GRD  = 3;
  typedef struct {logic [1:0] sel; int trig;} wdt_row_type;
  wdt_row_type rows [4] = '{'{2'h0, T0}, '{2'h1, T1}, '{2'h2, T2}, '{2'h3, T3}};

  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        sel_a   = 1'b0;
  logic        sel_b   = 1'b0;
  logic        low_cur = 1'b0;
  logic        svc_on  = 1'b0;
  logic        dis_on  = 1'b0;
  logic        svc;
  logic        dis;
  logic        fault_n;
  logic        irq;
  logic [3:0]  awaddr  = 4'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [3:0]  araddr  = 4'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic [3:0]  wstrb   = 4'hf;
  logic [7:0]  half    = 8'h14;
  logic [1:0]  resp;
  logic [31:0] d;
  int          falls;
  int          f0;
  int          n;
  int          lo;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  // Short counts keep the run brief; the low-time and window checks scale from them
  wdt_top #(.TRIG0_TICKS(T0), .TRIG1_TICKS(T1), .TRIG2_TICKS(T2), .TRIG3_TICKS(T3),
    .IGN_TICKS(IGN), .FLOW_TICKS(FLOW), .FILTER_TICKS(FILT), .GUARD_TICKS(GRD)) dut_u (
    .CLK(clk), .SRST(srst), .WINDOW_SELECT_A(sel_a), .WINDOW_SELECT_B(sel_b),
    .SERVICE_INPUT(svc), .LOW_CURRENT(low_cur), .DISABLE_LEVEL(dis),
    .FAULT_OUTPUT_N(fault_n), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  wdt_mcu_model mcu_u (.clk(clk), .svc_on(svc_on), .dis_on(dis_on), .half(half),
    .fault_n(fault_n), .service(svc), .disable_lvl(dis), .falls(falls));

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Tick phase against the edges allows about one tick of slack
  task automatic chkn(input string nm, input int e, input int g);
    cmp_count++;
    if (g < e - 12 || g > e + 12) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_f(input logic v, output int c);
    c = 0;
    while (fault_n !== v) begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic set_src(input int s, input logic v);
    if (s == 0) low_cur <= v;
    else dis_on <= v;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("fault_n after reset", 1, fault_n);
    chk("irq after reset", 0, irq);
    rd(REG_STATUS, d);
    chk("status reset", 32'(STATUS_RST), d);
    rd(REG_ENABLE, d);
    chk("enable reset", 32'(ENABLE_RST), d);
    foreach (rows[i]) begin
      sel_a <= rows[i].sel[0];
      sel_b <= rows[i].sel[1];
      wait_f(1'b0, n);
      wait_f(1'b1, lo);
      wait_f(1'b0, n);
      chkn("fault low time", FLOW * TK, lo);
      chkn("ignore plus window", (IGN + rows[i].trig) * TK, n);
    end
    wr(REG_ENABLE, 32'h1);
    wr(REG_CLEAR, 32'hf);
    rd(REG_STATUS, d);
    chk("status cleared", 0, d);
    chk("irq cleared", 0, irq);
    wait_f(1'b1, n);
    wait_f(1'b0, n);
    repeat (2) @(posedge clk);
    chk("irq on miss", 1, irq);
    wr(REG_ENABLE, 32'h0);
    @(posedge clk);
    chk("irq masked", 0, irq);
    wr(REG_CLEAR, 32'h1);
    rd(REG_STATUS, d);
    chk("miss bit cleared", 0, d[EV_MISS]);
    // Lane 0 off or an unmapped offset must leave the registers alone
    wstrb <= 4'h0;
    wr(REG_ENABLE, 32'hf);
    chk("bresp lane off", 32'(RESP_OKAY), resp);
    wstrb <= 4'hf;
    rd(REG_ENABLE, d);
    chk("enable kept without lane", 0, d);
    chk("rresp okay", 32'(RESP_OKAY), resp);
    wr(4'h2, 32'hf);
    chk("bresp unmapped", 32'(RESP_DECERR), resp);
    rd(4'h2, d);
    chk("rresp unmapped", 32'(RESP_DECERR), resp);
    chk("rdata unmapped", 0, d);
    svc_on <= 1'b1;
    f0 = falls;
    repeat (800) @(posedge clk);
    chk("no fault while serviced", f0, falls);
    rd(REG_STATUS, d);
    chk("service event seen", 1, d[EV_SERVICE]);
    svc_on <= 1'b0;
    wait_f(1'b0, n);
    chk("fault soon after service stops", 1, n <= 120);
    for (int s = 0; s < 2; s++) begin
      wait_f(1'b1, n);
      wr(REG_CLEAR, 32'hf);
      set_src(s, 1'b1);
      repeat (30) @(posedge clk);
      set_src(s, 1'b0);
      repeat (10) @(posedge clk);
      rd(REG_STATE, d);
      chk("active after short pulse", 1, d[3]);
      set_src(s, 1'b1);
      repeat (40) @(posedge clk);
      rd(REG_STATE, d);
      chk("active before filter", 1, d[3]);
      repeat (30) @(posedge clk);
      rd(REG_STATE, d);
      chk("inactive after hold", 0, d[3]);
      f0 = falls;
      repeat (400) @(posedge clk);
      chk("no fault while off", f0, falls);
      set_src(s, 1'b0);
      repeat (70) @(posedge clk);
      rd(REG_STATE, d);
      chk("active again", 1, d[3]);
      rd(REG_STATUS, d);
      chk("off and on events", 2'b11, d[EV_REACT:EV_DEACT]);
      wait_f(1'b0, n);
    end
    // A glitch shorter than the guard must leave the straps as they were
    sel_b <= 1'b0;
    repeat (15) @(posedge clk);
    sel_b <= 1'b1;
    repeat (20) @(posedge clk);
    rd(REG_STATE, d);
    chk("straps kept after glitch", 2'b11, d[7:6]);
    sel_b <= 1'b0;
    repeat (60) @(posedge clk);
    rd(REG_STATE, d);
    chk("straps taken when stable", 2'b01, d[7:6]);
    // Reset in mid-run, taken while the fault output is low
    wait_f(1'b0, n);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("fault_n after second reset", 1, fault_n);
    chk("irq after second reset", 0, irq);
    wait_f(1'b0, n);
    chkn("ignore plus window after reset", (IGN + T1) * TK, n);
    finish_test();
  end
endmodule

// [tb/wdt_mcu_model.sv]
`timescale 1ns/1ps
module wdt_mcu_model (
  input  wire logic       clk,
  input  wire logic       svc_on,
  input  wire logic       dis_on,
  input  wire logic [7:0] half,
  input  wire logic       fault_n,
  output logic            service,
  output logic            disable_lvl,
  output int              falls
);
  logic [7:0] cnt_q;
  logic       fault_q;

  initial begin
    cnt_q = 8'h00;
    fault_q = 1'b1;
    service = 1'b1;
    disable_lvl = 1'b0;
    falls = 0;
  end

  always @(posedge clk) begin
    fault_q <= fault_n;
    if (fault_q === 1'b1 && fault_n === 1'b0) begin
      falls <= falls + 1;
    end
    // Mid level held as long as asked, from a pulse shorter than the filter time to well past it
    disable_lvl <= dis_on;
    if (dis_on) begin
      // Mid-level pin reads high, so it shows no edges
      service <= 1'b1;
      cnt_q <= 8'h00;
    end else if (svc_on) begin
      // Half is never under ten cycles, one tick per phase at least
      if (cnt_q + 8'h01 >= half) begin
        service <= ~service;
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else begin
      service <= 1'b1;
      cnt_q <= 8'h00;
    end
  end
endmodule
